/* File: common/lsau_regs.svh */
// constants shared by the load/store address unit
`ifndef LSAU_REGS_SVH
`define LSAU_REGS_SVH
`define LSAU_WORD_STEP   32'h0000_0004
`define LSAU_PC_INDEX    4'hF
`define LSAU_BRANCH_MASK 32'hFFFF_FFFE
`define LSAU_UNPRIV_MSB  7
`define LSAU_PAIR_MSB    9
`define LSAU_BYTE_MSB    7
`define LSAU_HALF_MSB    15
`define LSAU_SIGN_BYTE   7
`define LSAU_SIGN_HALF   15
`endif

/* File: common/lsau_pkg.sv */
// types of the load/store address unit
package lsau_pkg;
	typedef enum logic [2:0] {
		kind_reg_offset = 3'h0,
		kind_unpriv     = 3'h1,
		kind_pc_rel     = 3'h2,
		kind_pc_pair    = 3'h3,
		kind_multi      = 3'h4,
		kind_imm_offset = 3'h5
	} lsau_kind_e;
	typedef enum logic [1:0] {
		size_byte = 2'h0,
		size_half = 2'h1,
		size_word = 2'h2
	} lsau_size_e;
	typedef enum logic [3:0] {
		mf_load_multi_op           = 4'h0,
		mf_load_multi_ascending    = 4'h1,
		mf_full_desc_load_alias    = 4'h2,
		mf_load_multi_descending   = 4'h3,
		mf_empty_asc_load_alias    = 4'h4,
		mf_store_multi_op          = 4'h5,
		mf_store_multi_ascending   = 4'h6,
		mf_empty_asc_store_alias   = 4'h7,
		mf_store_multi_descending  = 4'h8,
		mf_full_desc_store_alias   = 4'h9
	} lsau_multi_e;
	typedef enum logic [2:0] {
		st_idle   = 3'b001,
		st_setup  = 3'b010,
		st_access = 3'b100
	} lsau_state_e;
	typedef struct packed {
		lsau_kind_e  kind;
		lsau_size_e  size;
		logic        sgn;
		logic        is_load;
		logic        sub;
		logic        privileged;
		logic        wback;
		lsau_multi_e form;
		logic [3:0]  rt;
		logic [3:0]  rt2;
		logic [3:0]  rn;
		logic [1:0]  shift;
		logic [11:0] imm;
		logic [15:0] reglist;
		logic [31:0] base;
		logic [31:0] index;
	} lsau_req_s;
	typedef struct packed {
		logic [31:0] addr;
		logic        write;
		logic [31:0] wdata;
		lsau_size_e  size;
		logic        unpriv;
	} lsau_mem_s;
endpackage

/* File: hw/lsau_core.sv */
// load/store address unit: single, pair and multiple transfers
// Notes on behaviour
// (RULE1) register offset: base plus index shifted 0-3
// (RULE2) unsigned byte/half loads zero-extend to 32
// (RULE3) signed sizes only load, sign-extend to 32
// (RULE4) software: index not stack/pc, base not pc
// (RULE5) software: stack/pc transfer only word-sized
// (RULE6) word load to pc branches, bit0 cleared
// (RULE7) software: conditional pc load ends if_then_block
// (RULE8) condition flags never altered
// (RULE9) unprivileged variants access with user permission
// (RULE10) unprivileged variants equal normal in user mode
// (RULE11) unprivileged offset 0-255 added to base
// (RULE12) software: unprivileged base/transfer restrictions
// (RULE13) pc-relative: pc plus signed offset
// (RULE14) software: pair registers distinct, second legal
// (RULE15) multiple moves words, ascending by default
// (RULE16) ascending: upward, lowest register first, writeback
// (RULE17) descending: downward, highest register first, writeback
// (RULE18) base updated only with writeback suffix
// (RULE19) stack aliases map onto ascending/descending
// (RULE20) plain immediate: base plus/minus, no writeback
// (RULE21) unprivileged accesses carry unprivileged attribute
// (RULE22) illegal operand encodings are not detected
`timescale 1ns/1ps
`include "lsau_regs.svh"
module lsau_core (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// decoded request
	input  wire logic             req_valid,
	output logic                  req_ready,
	input  wire lsau_pkg::lsau_req_s req,
	// register file
	output logic [3:0]            rf_rd_idx,
	input  wire logic [31:0]      rf_rd_data,
	output logic                  rf_we,
	output logic [3:0]            rf_idx,
	output logic [31:0]           rf_data,
	output logic                  wb_we,
	output logic [3:0]            wb_idx,
	output logic [31:0]           wb_data,
	output logic                  flags_we,
	// branch and completion
	output logic                  br_valid,
	output logic [31:0]           br_target,
	output logic                  done,
	// memory system
	output logic                  mem_req,
	output lsau_pkg::lsau_mem_s   mem,
	input  wire logic             mem_ack,
	input  wire logic [31:0]      mem_rdata
);
	import lsau_pkg::*;

	function automatic logic [31:0] ext_load(lsau_size_e s, logic sg, logic [31:0] d);
		logic [31:0] r;
		r = d;
		case (s)
			size_byte: r = {{24{sg & d[`LSAU_SIGN_BYTE]}}, d[`LSAU_BYTE_MSB:0]};
			size_half: r = {{16{sg & d[`LSAU_SIGN_HALF]}}, d[`LSAU_HALF_MSB:0]};
			default:   r = d;
		endcase
		return r;
	endfunction

	function automatic logic [3:0] pick_reg(logic [15:0] l, logic up);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (up && l[15 - i])
				r = 4'(15 - i);
			if (!up && l[i])
				r = 4'(i);
		end
		return r;
	endfunction

	function automatic logic [4:0] pop_count(logic [15:0] l);
		logic [4:0] c;
		c = 5'h00;
		for (int i = 0; i < 16; i++)
			c = c + {4'h0, l[i]};
		return c;
	endfunction

	// returns {is_load, ascending}
	function automatic logic [1:0] decode_multi(lsau_multi_e f);
		logic [1:0] r;
		r = 2'h3;
		case (f)
			mf_load_multi_op, mf_load_multi_ascending, mf_full_desc_load_alias:     r = 2'h3;
			mf_load_multi_descending, mf_empty_asc_load_alias:                    r = 2'h2;
			mf_store_multi_op, mf_store_multi_ascending, mf_empty_asc_store_alias: r = 2'h1;
			mf_store_multi_descending, mf_full_desc_store_alias:                  r = 2'h0;
			default: r = 2'h3;
		endcase
		return r;
	endfunction

	lsau_state_e state;
	lsau_req_s   op;
	logic [15:0] remain;
	logic [31:0] addr;
	logic [31:0] wb_calc;
	logic [3:0]  cur_reg;
	logic        is_load;
	logic        asc;
	logic        phase;

	// (RULE22) no operand legality check; illegal encodings run as given
	wire         req_fire  = req_valid && (state == st_idle);
	wire         is_multi  = (req.kind == kind_multi);
	wire         is_pair   = (req.kind == kind_pc_pair);
	wire [1:0]   multi_dec = decode_multi(req.form);
	wire [31:0]  imm_ext   = {20'h00000, req.imm};
	wire [31:0]  pair_ext  = {22'h000000, req.imm[`LSAU_PAIR_MSB:0]};
	wire [31:0]  unp_ext   = {24'h000000, req.imm[`LSAU_UNPRIV_MSB:0]};
	// (RULE1) scaled index
	wire [31:0]  addr_reg  = req.base + (req.index << req.shift);
	// (RULE11) non-negative 8-bit offset
	wire [31:0]  addr_unp  = req.base + unp_ext;
	// (RULE13) (RULE20) signed offset, base carries pc for pc-relative
	wire [31:0]  addr_imm  = req.sub ? req.base - imm_ext : req.base + imm_ext;
	wire [31:0]  addr_pair = req.sub ? req.base - pair_ext : req.base + pair_ext;
	wire [31:0]  start_addr = (req.kind == kind_reg_offset) ? addr_reg :
	                          (req.kind == kind_unpriv)     ? addr_unp :
	                          is_pair                       ? addr_pair :
	                          is_multi                      ? req.base : addr_imm;
	wire [4:0]   pop_m1    = pop_count(req.reglist) - 5'h01;
	wire [31:0]  span      = {25'h0000000, pop_m1, 2'h0};
	// (RULE16) (RULE17) final transfer address
	wire [31:0]  next_wb   = multi_dec[0] ? req.base + span : req.base - span;
	wire         start_load = is_multi ? multi_dec[1] :
	                          (is_pair || req.kind == kind_pc_rel) ? 1'b1 : req.is_load;
	// (RULE16) (RULE17) ascending takes lowest register first, descending highest
	wire [3:0]   sel_reg   = (op.kind == kind_multi) ? pick_reg(remain, asc) :
	                         phase ? op.rt2 : op.rt;
	wire [31:0]  next_addr = asc ? addr + `LSAU_WORD_STEP : addr - `LSAU_WORD_STEP;
	wire         more      = (op.kind == kind_multi) ? (remain != 16'h0000) :
	                         (op.kind == kind_pc_pair) && !phase;
	wire [31:0]  load_val  = ext_load(op.size, op.sgn, mem_rdata);
	// (RULE9) (RULE10) (RULE21) user mode makes every access unprivileged
	wire         unpriv    = (op.kind == kind_unpriv) || !op.privileged;

	assign req_ready = (state == st_idle);
	assign rf_rd_idx = sel_reg;
	// (RULE8) flags never written
	assign flags_we  = 1'b0;

	always_ff @(posedge clk) begin
		rf_we    <= 1'b0;
		br_valid <= 1'b0;
		wb_we    <= 1'b0;
		done     <= 1'b0;
		if (rst) begin
			state <= st_idle; op <= '0; remain <= 16'h0000; addr <= 32'h0; wb_calc <= 32'h0;
			cur_reg <= 4'h0; is_load <= 1'b0; asc <= 1'b1; phase <= 1'b0; mem_req <= 1'b0;
			mem <= '0; rf_idx <= 4'h0; rf_data <= 32'h0; wb_idx <= 4'h0; wb_data <= 32'h0;
			br_target <= 32'h0;
		end else begin
			case (state)
				st_idle: if (req_fire) begin
					op <= req;
					// (RULE15) multiple and pair move whole words
					if (is_multi || is_pair)
						op.size <= size_word;
					// (RULE3) signed only on loads
					op.sgn <= req.sgn && start_load;
					// (RULE19) alias decides direction
					asc     <= is_multi ? multi_dec[0] : 1'b1;
					is_load <= start_load;
					addr    <= start_addr;
					wb_calc <= next_wb;
					remain  <= req.reglist;
					phase   <= 1'b0;
					state   <= st_setup;
				end
				st_setup: begin
					cur_reg    <= sel_reg;
					remain     <= remain & ~(16'h0001 << sel_reg);
					mem.addr   <= addr;
					mem.write  <= !is_load;
					mem.wdata  <= rf_rd_data;
					mem.size   <= op.size;
					mem.unpriv <= unpriv;
					mem_req    <= 1'b1;
					state      <= st_access;
				end
				st_access: if (mem_ack) begin
					mem_req <= 1'b0;
					phase   <= 1'b1;
					addr    <= next_addr;
					if (is_load) begin
						// (RULE6) pc load becomes a halfword-aligned branch
						if (cur_reg == `LSAU_PC_INDEX) begin
							br_valid  <= 1'b1;
							br_target <= mem_rdata & `LSAU_BRANCH_MASK;
						end else begin
							// (RULE2) (RULE3) extended result
							rf_we   <= 1'b1;
							rf_idx  <= cur_reg;
							rf_data <= load_val;
						end
					end
					if (more) begin
						state <= st_setup;
					end else begin
						done  <= 1'b1;
						// (RULE18) base written only with suffix
						wb_we   <= (op.kind == kind_multi) && op.wback;
						wb_idx  <= op.rn;
						wb_data <= wb_calc;
						state   <= st_idle;
					end
				end
				default: state <= st_idle;
			endcase
		end
	end

	reg_addr_a: assert property (@(posedge clk) disable iff (rst) // (RULE1)
		req_fire && req.kind == kind_reg_offset |-> ##2
		mem.addr == $past(req.base, 2) + ($past(req.index, 2) << $past(req.shift, 2)))
		else $error("register offset address wrong");
	zero_ext_a: assert property (@(posedge clk) disable iff (rst) // (RULE2)
		rf_we && op.size == size_byte && !op.sgn |-> rf_data[31:8] == 24'h000000)
		else $error("byte load not zero extended");
	sign_ext_a: assert property (@(posedge clk) disable iff (rst) // (RULE3)
		rf_we && op.size == size_half && op.sgn |-> rf_data[31:16] == {16{rf_data[15]}})
		else $error("half load not sign extended");
	pc_branch_a: assert property (@(posedge clk) disable iff (rst) // (RULE6)
		mem_ack && is_load && cur_reg == `LSAU_PC_INDEX |=>
		br_valid && !rf_we && br_target == {$past(mem_rdata[31:1]), 1'b0})
		else $error("pc load did not branch");
	no_flags_a: assert property (@(posedge clk) disable iff (rst) // (RULE8)
		done |-> !flags_we)
		else $error("flags written");
	unpriv_attr_a: assert property (@(posedge clk) disable iff (rst) // (RULE9)
		mem_req && (op.kind == kind_unpriv || !op.privileged) |-> mem.unpriv)
		else $error("unprivileged attribute missing");
	unpriv_imm_a: assert property (@(posedge clk) disable iff (rst) // (RULE11)
		req_fire && req.kind == kind_unpriv |-> ##2
		mem.addr == $past(req.base, 2) + {24'h000000, $past(req.imm[7:0], 2)})
		else $error("unprivileged offset wrong");
	multi_step_a: assert property (@(posedge clk) disable iff (rst) // (RULE16)
		mem_ack && op.kind == kind_multi && more |-> ##2
		mem.addr == (asc ? $past(mem.addr, 2) + 32'h4 : $past(mem.addr, 2) - 32'h4))
		else $error("multiple step not four bytes");
	multi_word_a: assert property (@(posedge clk) disable iff (rst) // (RULE15)
		mem_req && op.kind == kind_multi |-> mem.size == size_word)
		else $error("multiple access not word");
	wb_only_a: assert property (@(posedge clk) disable iff (rst) // (RULE18)
		wb_we |-> op.kind == kind_multi && op.wback && $past(state) == st_access)
		else $error("base written without suffix");
	alias_dir_a: assert property (@(posedge clk) disable iff (rst) // (RULE19)
		req_fire && is_multi && req.form == mf_full_desc_store_alias |=> !asc && !is_load)
		else $error("store alias direction wrong");
endmodule // lsau_core

/* File: test/lsau_mem_model.sv */
// memory system partner for the load/store address unit
`timescale 1ns/1ps
module lsau_mem_model (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// pacing: slow adds three wait cycles per access
	input  wire logic                slow,
	// memory bus
	input  wire logic                mem_req,
	input  wire lsau_pkg::lsau_mem_s mem,
	output logic                     mem_ack,
	output logic [31:0]              mem_rdata
);
	import lsau_pkg::*;
	logic [1:0]  wait_cnt;
	logic [31:0] last;
	wire  [31:0] word_val = {~mem.addr[7:0], mem.addr[7:0], ~mem.addr[7:0], mem.addr[7:0]};
	assign mem_ack = mem_req && (!slow || wait_cnt == 2'h3);
	// read data is only valid with ack; otherwise it toggles each cycle between the inverse of the last acked word and that word
	assign mem_rdata = mem_ack ? word_val : ~last;
	always_ff @(posedge clk) begin
		if (rst) begin
			wait_cnt <= 2'h0;
			last <= 32'h0;
		end else begin
			wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
			last <= mem_ack ? word_val : ~last;
		end
	end
endmodule // lsau_mem_model

/* File: test/testbench.sv */
// self-checking bench for the load/store address unit
`timescale 1ns/1ps
`include "lsau_regs.svh"
module testbench;
	import lsau_pkg::*;
	logic        clk, rst, req_valid, slow, mem_ack, req_ready, rf_we, wb_we;
	logic        flags_we, br_valid, done, mem_req;
	lsau_req_s   req;
	lsau_mem_s   mem;
	logic [3:0]  rf_rd_idx, rf_idx, wb_idx;
	logic [31:0] rf_rd_data, rf_data, wb_data, br_target, mem_rdata;
	int          failures, checks;
	lsau_mem_s   acc[$];
	logic [31:0] rfd[$], wbq[$], brq[$];
	logic [3:0]  rfi[$];
	assign rf_rd_data = {4{4'hA, rf_rd_idx}};
	lsau_core u_dut (.clk, .rst, .req_valid, .req_ready, .req, .rf_rd_idx, .rf_rd_data, .rf_we,
		.rf_idx, .rf_data, .wb_we, .wb_idx, .wb_data, .flags_we, .br_valid, .br_target, .done,
		.mem_req, .mem, .mem_ack, .mem_rdata);
	lsau_mem_model u_mem (.clk, .rst, .slow, .mem_req, .mem, .mem_ack, .mem_rdata);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] mval(input logic [31:0] a);
		return {~a[7:0], a[7:0], ~a[7:0], a[7:0]};
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic run(input lsau_req_s r);
		acc.delete(); rfd.delete(); rfi.delete(); wbq.delete(); brq.delete();
		@(posedge clk);
		req <= r;
		req_valid <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			if (req_ready === 1'b1) break;
		end
		@(posedge clk);
		req_valid <= 1'b0;
		for (int n = 0; n < 100; n++) begin
			@(negedge clk);
			check(flags_we, 1'b0);
			if (mem_req && mem_ack) acc.push_back(mem);
			if (rf_we) begin
				rfd.push_back(rf_data);
				rfi.push_back(rf_idx);
			end
			if (wb_we) wbq.push_back(wb_data);
			if (wb_we) check(wb_idx, r.rn);
			if (br_valid) brq.push_back(br_target);
			if (done) break;
		end
		check(done, 1'b1);
	endtask
	task automatic t_regoff();
		lsau_req_s r;
		logic [31:0] a, d, e;
		for (int sh = 0; sh < 4; sh++) for (int z = 0; z < 5; z++) begin
			r = '0; r.kind = kind_reg_offset; r.is_load = 1'b1; r.rt = 4'h5; r.rn = 4'h2;
			r.size = lsau_size_e'(z / 2); r.sgn = z[0] && z < 4; r.privileged = 1'b1;
			r.shift = sh[1:0]; r.base = 32'h2000_0000; r.index = 32'h0000_0021;
			run(r);
			a = r.base + (r.index << sh);
			d = mval(a);
			e = z == 0 ? {24'h0, d[7:0]} : z == 1 ? {{24{d[7]}}, d[7:0]} :
				z == 2 ? {16'h0, d[15:0]} : z == 3 ? {{16{d[15]}}, d[15:0]} : d;
			check(acc[0].addr, a);
			check(rfd[0], e);
		end
		r.is_load = 1'b0; r.rt = 4'h3;
		run(r);
		check({acc[0].write, acc[0].wdata}, {1'b1, 32'hA3A3_A3A3});
		check(rfd.size(), 0);
	endtask
	task automatic t_unpriv();
		lsau_req_s r;
		for (int k = 0; k < 2; k++) for (int p = 0; p < 2; p++) begin
			r = '0; r.kind = k ? kind_unpriv : kind_imm_offset; r.privileged = p[0];
			r.imm = 12'h0FF; r.sub = !k; r.base = 32'h3000_0100; r.size = size_word;
			r.is_load = 1'b1; r.rt = 4'h1; r.rn = 4'h6;
			run(r);
			check(acc[0].addr, k ? 32'h3000_01FF : 32'h3000_0001);
			check(acc[0].unpriv, k || !p);
			check(wbq.size(), 0);
		end
	endtask
	task automatic t_pcrel();
		lsau_req_s r;
		for (int s = 0; s < 2; s++) begin
			r = '0; r.kind = kind_pc_rel; r.imm = 12'hFFF; r.sub = s[0];
			r.base = 32'h0000_8000; r.size = size_word; r.rt = 4'h2;
			run(r);
			check(acc[0].addr, s ? 32'h0000_7001 : 32'h0000_8FFF);
		end
		r.kind = kind_pc_pair; r.imm = 12'h3FC; r.sub = 1'b0; r.rt2 = 4'h3;
		run(r);
		for (int k = 0; k < 2; k++) begin
			check(acc[k].addr, 32'h0000_83FC + 4 * k);
			check({rfi[k], rfd[k]}, {4'h2 + k[3:0], mval(32'h0000_83FC + 4 * k)});
		end
	endtask
	task automatic t_branch();
		lsau_req_s r;
		r = '0; r.kind = kind_reg_offset; r.is_load = 1'b1; r.size = size_word;
		r.rt = `LSAU_PC_INDEX; r.base = 32'h0000_0081;
		run(r);
		check(brq[0], 32'h7E81_7E80);
		check(rfd.size(), 0);
	endtask
	task automatic t_multi();
		lsau_req_s r;
		logic [3:0] regs[4] = '{4'h1, 4'h4, 4'h9, 4'hB};
		logic [3:0] rg;
		logic [31:0] a;
		logic desc;
		slow <= 1'b1;
		for (int f = 0; f < 10; f++) begin
			r = '0; r.kind = kind_multi; r.form = lsau_multi_e'(f); r.wback = f[0];
			r.reglist = 16'h0A12; r.base = 32'h4000_0040;
			desc = f inside {3, 4, 8, 9};
			run(r);
			for (int k = 0; k < 4; k++) begin
				rg = desc ? regs[3 - k] : regs[k];
				a = desc ? r.base - 4 * k : r.base + 4 * k;
				check({acc[k].addr, acc[k].size}, {a, size_word});
				if (f < 5) check({rfi[k], rfd[k]}, {rg, mval(a)});
				else check(acc[k].wdata, {4{4'hA, rg}});
			end
			check(wbq.size(), f % 2);
			if (f[0]) check(wbq[0], desc ? r.base - 12 : r.base + 12);
		end
		slow <= 1'b0;
	endtask
	initial begin
		rst = 1'b1; req_valid = 1'b0; req = '0; slow = 1'b0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_regoff();
		t_unpriv();
		t_pcrel();
		t_branch();
		t_multi();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		conclude();
	end
endmodule // testbench
